// ===== logic/secure_companion_twi_front.sv
// Two-wire slave front end of the security coprocessor
// Summary of operation
// - Accept commands 60 ms after reset release; longer when a penalty is pending.
// - Active-low reset clears all state regardless of the sleep pin.
// - Sleep pin high: sleep and ignore all bus line transitions.
// - After the sleep pin falls, ignore the bus for 50 ms.
// - Slave only; the clock line is never held low.
// - Address bit 1 selects command/data (one) or status byte (zero).
// - Address bit 0 gives direction: one is read, zero is write.
// - First byte of a command write is the command ordinal; reads carry none.
// - Size byte precedes operand and result bytes; absent from status reads.
// - Respond only when upper six address bits match the stored field.
// - Stored bus address field starts at 0xC0.
// - While busy, NACK command/data addresses; status stays reachable.
// - ACK legal ordinals; ordinal 0x15 or above starts a penalty stall.
// - Status: result ready, busy, start-up done, zeros, error code 7..5.
`timescale 1ns/1ps
module secure_companion_twi_front import twi_front_pkg::*; #(
    parameter int STARTUP_CYCLES = STARTUP_CYC,
    parameter int WAKE_CYCLES = WAKE_CYC,
    parameter int PENALTY_CYCLES = PENALTY_CYC
) (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    output logic scl_oe_o,
    input wire logic sleep_request_pin_i,
    input wire logic addr_wr_i,
    input wire logic [7:0] addr_wdata_i,
    input wire logic core_busy_i,
    input wire logic result_ready_flag_i,
    input wire logic startup_complete_flag_i,
    input wire logic [ERR_W-1:0] error_code_i,
    input wire logic penalty_pending_i,
    output logic cmd_valid_o,
    output logic [7:0] cmd_data_o,
    output logic cmd_first_o,
    input wire logic cmd_ready_i,
    input wire logic [7:0] rd_byte_i,
    output logic rd_start_o,
    output logic rd_next_o,
    output logic ready_o,
    output logic penalty_o
);
    twi_state_e st;
    logic scl_q, sda_q, scl_rise, scl_fall, start_cond, stop_cond;
    logic [7:0] shreg, tx_byte, dev_field, status_byte, next_tx;
    logic [2:0] bitcnt;
    logic [1:0] byte_idx;
    logic is_read, is_status, ack_flag, ack_bit, mack, next_ack;
    logic sleep_request_state, booted, hold_active, pen_active, holdoff, busy_any;
    logic hold_load, pen_load, addr_match, next_oe;
    logic [TMR_W-1:0] hold_val;
    fifo_if #(.W(FIFO_W)) cf ();

    cmd_fifo #(.W(FIFO_W), .D(FIFO_D)) u_fifo (
        .mclk_i(mclk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .f(cf.store));

    assign scl_rise = scl_i && !scl_q;
    assign scl_fall = !scl_i && scl_q;
    assign start_cond = scl_i && scl_q && sda_q && !sda_i;
    assign stop_cond = scl_i && scl_q && !sda_q && sda_i;

    // Holdoff covers start-up, sleep and wake delay alike
    assign holdoff = !booted || hold_active || sleep_request_state || sleep_request_pin_i;
    assign busy_any = core_busy_i || pen_active;
    assign hold_load = !booted || (sleep_request_state && !sleep_request_pin_i);
    always_comb begin
        hold_val = TMR_W'(WAKE_CYCLES);
        if (!booted) begin
            hold_val = TMR_W'(STARTUP_CYCLES);
            if (penalty_pending_i) begin
                hold_val = TMR_W'(STARTUP_CYCLES) + TMR_W'(PENALTY_CYCLES);
            end
        end
    end

    hold_timer u_hold (
        .mclk_i(mclk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
        .load_i(hold_load), .load_val_i(hold_val), .active_o(hold_active));

    assign pen_load = (st == S_DEC) && (byte_idx == IDX_CMD) && !is_read
        && (shreg >= CMD_ILLEGAL_MIN);

    hold_timer u_pen (
        .mclk_i(mclk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
        .load_i(pen_load), .load_val_i(TMR_W'(PENALTY_CYCLES)), .active_o(pen_active));

    always_comb begin
        status_byte = '0;
        status_byte[ST_RDY] = result_ready_flag_i;
        status_byte[ST_BUSY] = busy_any;
        status_byte[ST_BOOT] = startup_complete_flag_i;
        status_byte[ST_ERR_LSB +: ERR_W] = error_code_i;
    end
    // Status reads send the status byte alone; command reads start at the size byte
    assign next_tx = is_status ? status_byte : rd_byte_i;

    assign addr_match = shreg[7:ADDR_MATCH_LSB] == dev_field[7:ADDR_MATCH_LSB];
    always_comb begin
        next_ack = cf.w_ready;  // No stretching, so a full FIFO can only refuse
        if (byte_idx == IDX_ADDR) begin
            next_ack = addr_match && !holdoff
                && !(shreg[SEL_BIT] && busy_any)
                && (shreg[SEL_BIT] || shreg[DIR_BIT]);
        end else if (byte_idx == IDX_CMD) begin
            next_ack = cf.w_ready && (shreg < CMD_ILLEGAL_MIN);
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            booted <= 1'b0;
            sleep_request_state <= 1'b0;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else if (ce_i) begin
            booted <= 1'b1;
            sleep_request_state <= sleep_request_pin_i;
            scl_q <= scl_i;
            sda_q <= sda_i;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dev_field <= DEV_ADDR_RESET;
        end else if (ce_i && addr_wr_i) begin
            dev_field <= addr_wdata_i;
        end
    end

    // Byte engine
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st <= S_IDLE;
            shreg <= '0;
            tx_byte <= '0;
            bitcnt <= '0;
            byte_idx <= IDX_ADDR;
            is_read <= 1'b0;
            is_status <= 1'b0;
            ack_flag <= 1'b0;
            ack_bit <= 1'b0;
            mack <= 1'b0;
        end else if (ce_i) begin
            if (sleep_request_pin_i) begin
                st <= S_IDLE;
                ack_bit <= 1'b0;
            end else if (start_cond) begin
                st <= S_RX;
                bitcnt <= '0;
                byte_idx <= IDX_ADDR;
                ack_bit <= 1'b0;
            end else if (stop_cond) begin
                st <= S_IDLE;
                ack_bit <= 1'b0;
            end else begin
                case (st)
                    S_RX: if (scl_rise) begin
                        shreg <= {shreg[6:0], sda_i};
                        bitcnt <= bitcnt + 1'b1;
                        if (bitcnt == BIT_LAST) begin
                            st <= S_DEC;
                        end
                    end
                    S_DEC: begin
                        ack_flag <= next_ack;
                        if (byte_idx == IDX_ADDR) begin
                            is_read <= shreg[DIR_BIT];
                            is_status <= !shreg[SEL_BIT];
                        end
                        st <= S_ACK;
                    end
                    S_ACK: if (scl_fall) begin
                        ack_bit <= !ack_bit;
                        bitcnt <= '0;
                        if (ack_bit && !ack_flag) begin
                            st <= S_IDLE;
                        end else if (ack_bit && is_read) begin
                            st <= S_TX;
                            tx_byte <= next_tx;
                        end else if (ack_bit) begin
                            st <= S_RX;
                            if (byte_idx != IDX_DATA) begin
                                byte_idx <= byte_idx + 1'b1;
                            end
                        end
                    end
                    S_TX: if (scl_fall) begin
                        bitcnt <= bitcnt + 1'b1;
                        if (bitcnt == BIT_LAST) begin
                            st <= S_RACK;
                        end
                    end
                    S_RACK: begin
                        if (scl_rise) begin
                            mack <= !sda_i;
                        end
                        if (scl_fall) begin
                            st <= mack ? S_TX : S_IDLE;
                            tx_byte <= next_tx;
                            bitcnt <= '0;
                        end
                    end
                    default: st <= S_IDLE;
                endcase
            end
        end
    end

    always_comb begin
        next_oe = 1'b0;
        if (st == S_ACK) begin
            next_oe = ack_bit && ack_flag;
        end else if (st == S_TX) begin
            next_oe = !tx_byte[BIT_LAST - bitcnt];
        end
        if (sleep_request_pin_i) begin
            next_oe = 1'b0;
        end
    end

    // Pin and handshake outputs
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sda_o <= 1'b0;
            sda_oe_o <= 1'b0;
            scl_oe_o <= 1'b0;
            ready_o <= 1'b0;
            penalty_o <= 1'b0;
            rd_start_o <= 1'b0;
            rd_next_o <= 1'b0;
            cf.w_valid <= 1'b0;
            cf.w_data <= '0;
        end else if (ce_i) begin
            sda_o <= 1'b0;
            sda_oe_o <= next_oe;
            scl_oe_o <= 1'b0;
            ready_o <= !holdoff;
            penalty_o <= pen_active;
            rd_start_o <= (st == S_DEC) && (byte_idx == IDX_ADDR) && next_ack
                && shreg[DIR_BIT] && shreg[SEL_BIT];
            rd_next_o <= (st == S_RACK) && scl_rise && !sda_i && !is_status;
            cf.w_valid <= (st == S_DEC) && (byte_idx != IDX_ADDR) && !is_read && next_ack;
            cf.w_data <= {byte_idx == IDX_CMD, shreg};
        end
    end

    // Output stage keeps the command stream registered
    assign cf.r_ready = !cmd_valid_o || cmd_ready_i;
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cmd_valid_o <= 1'b0;
            cmd_data_o <= '0;
            cmd_first_o <= 1'b0;
        end else if (ce_i && cf.r_ready) begin
            cmd_valid_o <= cf.r_valid;
            cmd_data_o <= cf.r_data[7:0];
            cmd_first_o <= cf.r_data[ENTRY_FIRST];
        end
    end

    default clocking cb @(posedge mclk_i iff ce_i); endclocking
    default disable iff (!rst_n_i);

    chk_sleep_quiet: assert property (sleep_request_pin_i |=> !sda_oe_o)
        else $error("sda driven while asleep");
    chk_wake_hold: assert property ($fell(sleep_request_pin_i) |=> !ready_o [*8])
        else $error("ready too soon after wake");
    chk_boot_hold: assert property ($rose(booted) |-> !ready_o [*8])
        else $error("ready too soon after reset");
    chk_no_stretch: assert property (!scl_oe_o)
        else $error("clock line driven");
    chk_addr_match: assert property ((st == S_DEC && byte_idx == IDX_ADDR && !addr_match)
        |=> !ack_flag)
        else $error("ack on foreign address");
    chk_busy_nack: assert property ((st == S_DEC && byte_idx == IDX_ADDR && shreg[SEL_BIT]
        && busy_any) |=> !ack_flag)
        else $error("command address acked while busy");
    chk_holdoff_nack: assert property ((st == S_DEC && byte_idx == IDX_ADDR && holdoff)
        |=> !ack_flag ##1 (st == S_ACK))
        else $error("address acked in holdoff");
    chk_illegal_cmd: assert property (pen_load |=> !ack_flag && pen_active ##1 penalty_o)
        else $error("illegal ordinal not penalised");
    chk_status_load: assert property ((st == S_ACK && scl_fall && ack_bit && ack_flag
        && is_read && is_status) |=> tx_byte == $past(status_byte))
        else $error("status byte not loaded");
    chk_addr_init: assert property (!$past(booted) && !$past(addr_wr_i)
        |-> dev_field == DEV_ADDR_RESET)
        else $error("address field not at reset value");

    cov_status_read: cover property (st == S_TX && is_status);
    cov_cmd_write: cover property (cmd_valid_o && cmd_first_o);
    cov_penalty: cover property (pen_load);
    cov_fifo_full: cover property (!cf.w_ready);
endmodule : secure_companion_twi_front

// ===== inc/twi_front_pkg.sv
// Shared constants, field positions and state type of the two-wire front end
package twi_front_pkg;
    localparam int CLK_HZ = 100_000_000;
    localparam int CYC_PER_MS = CLK_HZ / 1000;
    localparam int STARTUP_MS = 60;
    localparam int WAKE_MS = 50;
    localparam int PENALTY_MS = 100;
    localparam int STARTUP_CYC = STARTUP_MS * CYC_PER_MS;
    localparam int WAKE_CYC = WAKE_MS * CYC_PER_MS;
    localparam int PENALTY_CYC = PENALTY_MS * CYC_PER_MS;
    localparam int TMR_W = 32;
    localparam logic [7:0] DEV_ADDR_RESET = 8'hc0;
    localparam logic [7:0] CMD_ILLEGAL_MIN = 8'h15;
    localparam int ADDR_MATCH_LSB = 2;
    localparam int SEL_BIT = 1;
    localparam int DIR_BIT = 0;
    localparam int ST_RDY = 0;
    localparam int ST_BUSY = 1;
    localparam int ST_BOOT = 2;
    localparam int ST_ERR_LSB = 5;
    localparam int ERR_W = 3;
    localparam int FIFO_W = 9;
    localparam int FIFO_D = 16;
    localparam int ENTRY_FIRST = 8;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [1:0] IDX_ADDR = 2'h0;
    localparam logic [1:0] IDX_CMD = 2'h1;
    localparam logic [1:0] IDX_DATA = 2'h3;
    typedef enum logic [2:0] {S_IDLE, S_RX, S_DEC, S_ACK, S_TX, S_RACK} twi_state_e;
endpackage : twi_front_pkg

// ===== inc/fifo_if.sv
// Valid/ready carrier between the front end and its command byte FIFO
`timescale 1ns/1ps
interface fifo_if #(parameter int W = 9) ();
    logic w_valid;
    logic w_ready;
    logic [W-1:0] w_data;
    logic r_valid;
    logic r_ready;
    logic [W-1:0] r_data;
    modport user (output w_valid, w_data, r_ready, input w_ready, r_valid, r_data);
    modport store (input w_valid, w_data, r_ready, output w_ready, r_valid, r_data);
endinterface : fifo_if

// ===== logic/cmd_fifo.sv
// Command byte FIFO with honest full and empty
`timescale 1ns/1ps
module cmd_fifo #(
    parameter int W = 9,
    parameter int D = 16
) (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    fifo_if.store f
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem [D];
    logic [AW:0] wp;
    logic [AW:0] rp;
    logic full;
    logic empty;

    // Extra pointer bit tells full from empty without a counter
    assign full = (wp[AW] != rp[AW]) && (wp[AW-1:0] == rp[AW-1:0]);
    assign empty = (wp == rp);
    assign f.w_ready = !full;
    assign f.r_valid = !empty;
    assign f.r_data = mem[rp[AW-1:0]];

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wp <= '0;
        end else if (ce_i && f.w_valid && !full) begin
            wp <= wp + 1'b1;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rp <= '0;
        end else if (ce_i && f.r_ready && !empty) begin
            rp <= rp + 1'b1;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (ce_i && f.w_valid && !full) begin
            mem[wp[AW-1:0]] <= f.w_data;
        end
    end
endmodule : cmd_fifo

// ===== logic/hold_timer.sv
// Down counter that holds the longest of the intervals loaded into it
`timescale 1ns/1ps
module hold_timer import twi_front_pkg::*; (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic load_i,
    input wire logic [TMR_W-1:0] load_val_i,
    output logic active_o
);
    logic [TMR_W-1:0] cnt;

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt <= '0;
        end else if (ce_i) begin
            // A shorter load never cuts a running interval short
            if (load_i && load_val_i > cnt) begin
                cnt <= load_val_i;
            end else if (cnt != '0) begin
                cnt <= cnt - 1'b1;
            end
        end
    end

    assign active_o = (cnt != '0);
endmodule : hold_timer

// ===== testbench/bus_master.sv
// Bus master model: owns the clock line and shares the open-drain data line
`timescale 1ns/1ps
module bus_master #(parameter int HALF = 8) (
    input wire logic mclk_i,
    input wire logic dev_low_i,
    output logic scl_o,
    output logic sda_o
);
    logic pull = 1'b0;
    initial scl_o = 1'b1;
    // Board pull-up: the line reads high unless a party pulls it low
    assign sda_o = !(pull || dev_low_i);
    task automatic tick();
        repeat (HALF) @(negedge mclk_i);
    endtask : tick
    // Also serves as repeated start
    task automatic start();
        pull = 1'b0;
        tick();
        scl_o = 1'b1;
        tick();
        pull = 1'b1;
        tick();
        scl_o = 1'b0;
    endtask : start
    task automatic stop();
        pull = 1'b1;
        tick();
        scl_o = 1'b1;
        tick();
        pull = 1'b0;
        tick();
    endtask : stop
    // Data moves only while the clock is low; the clock is ours alone
    task automatic bit_x(input logic b, output logic r);
        pull = !b;
        tick();
        scl_o = 1'b1;
        tick();
        r = sda_o;
        scl_o = 1'b0;
    endtask : bit_x
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_x(d[i], r);
        bit_x(1'b1, r);
        ack = !r;
    endtask : wbyte
    task automatic rbyte(input logic mack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
        bit_x(!mack, r);
    endtask : rbyte
endmodule : bus_master

// ===== testbench/tb_top.sv
// Self-checking bench: bus master model, byte queues and pin checks
`timescale 1ns/1ps
module tb_top;
    // Short intervals keep the run small; every expectation derives from them
    localparam int SU = 400;
    localparam int WK = 300;
    localparam int PN = 1500;
    logic mclk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic sleep_request_pin_i = 1'b0;
    logic addr_wr_i = 1'b0;
    logic core_busy_i = 1'b0;
    logic result_ready_flag_i = 1'b0;
    logic startup_complete_flag_i = 1'b0;
    logic penalty_pending_i = 1'b0;
    logic cmd_ready_i = 1'b0;
    logic ce_i = 1'b1;
    logic stall = 1'b1;
    logic [7:0] addr_wdata_i = 8'h00;
    logic [7:0] rd_byte_i = 8'h00;
    logic [2:0] error_code_i = 3'h0;
    logic sda_o, sda_oe_o, scl_oe_o, cmd_valid_o, cmd_first_o, rd_start_o, rd_next_o;
    logic ready_o, penalty_o, scl_line, sda_line, ack;
    logic [7:0] cmd_data_o, d;
    logic [31:0] seed = 32'd37;
    logic [31:0] r;
    logic [8:0] exp_q[$];
    logic [8:0] got_q[$];
    logic [7:0] rd_src[$];
    int num_errors = 0;
    int compares = 0;
    int cyc = 0;
    int t0 = 0;
    int n_start = 0;
    int n_next = 0;
    int rd_idx = 0;
    int bad_pins = 0;
    bus_master #(.HALF(8)) i_bus_master (.mclk_i(mclk_i), .dev_low_i(sda_oe_o && !sda_o),
        .scl_o(scl_line), .sda_o(sda_line));
    secure_companion_twi_front #(.STARTUP_CYCLES(SU), .WAKE_CYCLES(WK), .PENALTY_CYCLES(PN))
        i_secure_companion_twi_front (.mclk_i, .rst_n_i, .ce_i, .scl_i(scl_line),
        .sda_i(sda_line), .sda_o, .sda_oe_o, .scl_oe_o, .sleep_request_pin_i, .addr_wr_i,
        .addr_wdata_i, .core_busy_i, .result_ready_flag_i, .startup_complete_flag_i,
        .error_code_i, .penalty_pending_i, .cmd_valid_o, .cmd_data_o, .cmd_first_o,
        .cmd_ready_i, .rd_byte_i, .rd_start_o, .rd_next_o, .ready_o, .penalty_o);
    always #5 mclk_i = ~mclk_i;
    function automatic logic [31:0] xr();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xr
    always @(posedge mclk_i) begin
        cyc <= cyc + 1;
        if (rd_start_o === 1'b1) n_start <= n_start + 1;
        if (rd_next_o === 1'b1) n_next <= n_next + 1;
        // Flops are unknown until the first edge under reset has clocked them
        if (cyc > 0 && (scl_oe_o !== 1'b0 || sda_o !== 1'b0)) bad_pins <= bad_pins + 1;
        if (rst_n_i && cmd_valid_o === 1'b1 && cmd_ready_i) begin
            got_q.push_back({cmd_first_o, cmd_data_o});
        end
    end
    // Consumer stays stalled until the FIFO test has filled the FIFO, then stalls at random
    always @(negedge mclk_i) begin
        cmd_ready_i <= !stall && (xr() > 32'h7fffffff);
        if (rd_start_o === 1'b1) rd_idx = 0;
        if (rd_start_o === 1'b1 || rd_next_o === 1'b1) begin
            rd_byte_i <= rd_src[rd_idx];
            rd_idx = rd_idx + 1;
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic tick(input int n);
        repeat (n) @(negedge mclk_i);
    endtask : tick
    task automatic done(input string s);
        $display("test %s done", s);
    endtask : done
    task automatic addr(input logic [7:0] a, input logic e);
        i_bus_master.start();
        i_bus_master.wbyte(a, ack);
        check(ack, e);
    endtask : addr
    task automatic stat_read(input logic [7:0] a, input logic busy);
        r = xr();
        error_code_i = r[2:0];
        result_ready_flag_i = r[3];
        startup_complete_flag_i = r[4];
        addr(a, 1'b1);
        i_bus_master.rbyte(1'b0, d);
        i_bus_master.stop();
        check(d, {error_code_i, 2'b00, startup_complete_flag_i, busy, result_ready_flag_i});
    endtask : stat_read
    task automatic wait_ready(input int lo);
        while (ready_o !== 1'b1 && cyc - t0 < 3000) tick(1);
        check(cyc - t0 >= lo && cyc - t0 <= lo + 6, 1);
    endtask : wait_ready
    task automatic final_report();
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : final_report
    initial begin
        repeat (40000) @(posedge mclk_i);
        num_errors++;
        final_report();
    end
    initial begin
        tick(6);
        rst_n_i = 1'b1;
        t0 = cyc;
        addr(8'hc1, 1'b0);
        i_bus_master.stop();
        wait_ready(SU);
        done("startup");
        for (int i = 0; i < 4; i++) begin
            r = xr();
            d = r[7:0];
            if (d[7:2] == 6'h30) d[7] = 1'b0;
            addr(d, 1'b0);
            i_bus_master.stop();
        end
        for (int i = 0; i < 3; i++) begin
            core_busy_i = i[0];
            stat_read(8'hc1, i[0]);
        end
        core_busy_i = 1'b1;
        addr(8'hc2, 1'b0);
        i_bus_master.stop();
        core_busy_i = 1'b0;
        addr(8'hc0, 1'b0);
        i_bus_master.stop();
        done("address");
        addr(8'hc2, 1'b1);
        for (int i = 0; i < 18; i++) begin
            r = xr();
            d = (i == 0) ? r[7:0] % 8'h15 : (i == 1) ? 8'h10 : r[7:0];
            i_bus_master.wbyte(d, ack);
            check(ack, i < 17);
            if (i < 17) exp_q.push_back({i == 0, d});
        end
        i_bus_master.stop();
        stall = 1'b0;
        done("fifo");
        r = xr();
        rd_src = '{8'h02, r[7:0], r[15:8]};
        addr(8'hc3, 1'b1);
        for (int i = 0; i < 3; i++) begin
            i_bus_master.rbyte(i < 2, d);
            check(d, rd_src[i]);
        end
        i_bus_master.stop();
        check(n_start * 4 + n_next, 6);
        done("output read");
        addr(8'hc2, 1'b1);
        i_bus_master.wbyte(8'h15, ack);
        i_bus_master.stop();
        check({ack, penalty_o}, 2'b01);
        addr(8'hc2, 1'b0);
        i_bus_master.stop();
        stat_read(8'hc1, 1'b1);
        t0 = cyc;
        while (penalty_o === 1'b1 && cyc - t0 < 3000) tick(1);
        check(cyc - t0 > 100 && cyc - t0 < PN, 1);
        addr(8'hc2, 1'b1);
        i_bus_master.wbyte(8'h14, ack);
        check(ack, 1'b1);
        i_bus_master.wbyte(8'h00, ack);
        check(ack, 1'b1);
        i_bus_master.stop();
        exp_q.push_back(9'h114);
        exp_q.push_back(9'h000);
        tick(200);
        check(got_q.size(), exp_q.size());
        foreach (exp_q[i]) check(got_q[i], exp_q[i]);
        done("penalty");
        sleep_request_pin_i = 1'b1;
        tick(4);
        check(ready_o, 1'b0);
        addr(8'hc1, 1'b0);
        i_bus_master.stop();
        sleep_request_pin_i = 1'b0;
        t0 = cyc;
        addr(8'hc1, 1'b0);
        i_bus_master.stop();
        wait_ready(WK);
        stat_read(8'hc1, 1'b0);
        // Clock enable low freezes all state, so a sleep request goes unseen
        ce_i = 1'b0;
        sleep_request_pin_i = 1'b1;
        tick(10);
        check(ready_o, 1'b1);
        sleep_request_pin_i = 1'b0;
        ce_i = 1'b1;
        done("sleep");
        addr_wdata_i = 8'h5c;
        addr_wr_i = 1'b1;
        tick(1);
        addr_wr_i = 1'b0;
        addr(8'hc1, 1'b0);
        i_bus_master.stop();
        stat_read(8'h5d, 1'b0);
        done("field");
        sleep_request_pin_i = 1'b1;
        penalty_pending_i = 1'b1;
        rst_n_i = 1'b0;
        tick(6);
        check({ready_o, penalty_o, cmd_valid_o}, 3'h0);
        sleep_request_pin_i = 1'b0;
        tick(1);
        rst_n_i = 1'b1;
        t0 = cyc;
        wait_ready(SU + PN);
        penalty_pending_i = 1'b0;
        stat_read(8'hc1, 1'b0);
        check(bad_pins, 0);
        done("reset");
        final_report();
    end
endmodule : tb_top
